// file: verilog/pdad_pkg.sv
// Package: constants and carrier types for the program/data address decoder
// Function
// - Data space spans 64K locations of 16-bit words.
// - Data addresses inside on-chip RAM bounds go to on-chip RAM automatically.
// - Data addresses outside on-chip RAM bounds, except the page register at 001Eh, start an external access.
// - On-chip accesses complete with no wait states.
// - With overlay on, program fetches inside on-chip range are served on-chip.
// - Program addresses outside on-chip program range issue an external access.
// - Paging extends program space to 8192K words.
// - Twenty-three program address lines are driven, not sixteen.
// - Program memory is 128 pages of 64K words each.
// - The page select register value picks the current program page.
// - Page select register is read/write in data space at 001Eh.
// - Hardware reset clears the page select register to zero.
// - Overlay bit at one maps dual-access RAM into program space too.
// - Overlay on: on-chip RAM in low part of every page; off: every program fetch is external, page 0 included.
package pdad_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int PDAD_DATA_W = 16;
  localparam int PDAD_ADDR_W = 16;
  localparam int PDAD_PAGE_W = 7;
  localparam int PDAD_XADDR_W = 23;

  // ----------------------------------------
  // Map constants
  // ----------------------------------------
  localparam logic [15:0] PDAD_PAGE_REG_ADDR = 16'h001E;
  localparam logic [15:0] PDAD_RAM_LO = 16'h0080;
  localparam logic [15:0] PDAD_RAM_HI = 16'h9FFF;
  localparam logic [6:0] PDAD_PAGE_RST = 7'h00;
  localparam logic [15:0] PDAD_RD_ZERO = 16'h0000;

  // Core request toward the decoder
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } pdad_req_t;

  // Routed access toward a memory
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [22:0] addr;
    logic [15:0] wdata;
  } pdad_route_t;

endpackage : pdad_pkg

// file: verilog/pdad_page_reg.sv
// Program page select register, memory mapped in data space
`timescale 1ns/1ps
module pdad_page_reg
  import pdad_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // Data-space access
  input wire pdad_req_t data_req_in,
  // Register state
  output logic [6:0] page_out,
  output logic hit_out
);

  typedef struct packed {
    logic [6:0] page;
  } pdad_preg_st_t;

  pdad_preg_st_t st_ff;
  pdad_preg_st_t nxt_st;

  assign hit_out = data_req_in.valid && (data_req_in.addr == PDAD_PAGE_REG_ADDR);
  assign page_out = st_ff.page;

  always_comb begin
    nxt_st = st_ff;
    if (hit_out && data_req_in.write) begin
      nxt_st.page = data_req_in.wdata[6:0];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      st_ff.page <= PDAD_PAGE_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  page_reset_a: assert property (@(posedge sys_clk_in)
    !nrst_in |=> page_out == PDAD_PAGE_RST)
    else $error("page register not cleared by reset");

endmodule // pdad_page_reg

// file: verilog/pdad_decoder.sv
// Top: data and program address decoder with program paging
`timescale 1ns/1ps
module pdad_decoder
  import pdad_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // Configuration
  input wire logic ram_overlay_enable_in,
  // Core requests
  input wire pdad_req_t data_req_in,
  input wire pdad_req_t prog_req_in,
  // On-chip memory side
  output pdad_route_t ram_data_out,
  output pdad_route_t ram_prog_out,
  input wire logic [15:0] ram_data_rdata_in,
  input wire logic [15:0] ram_prog_rdata_in,
  // External memory side
  output pdad_route_t ext_data_out,
  output pdad_route_t ext_prog_out,
  input wire logic [15:0] ext_data_rdata_in,
  input wire logic [15:0] ext_prog_rdata_in,
  input wire logic ext_ready_in,
  // Answers to the core
  output logic [15:0] data_rdata_out,
  output logic [15:0] prog_rdata_out,
  output logic wait_out,
  output logic [22:0] prog_xaddr_out
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic        ram_overlay_enable_s1;
    logic        ram_overlay_enable;
    logic        ready;
    pdad_route_t ram_d;
    pdad_route_t ram_p;
    pdad_route_t ext_d;
    pdad_route_t ext_p;
    logic [15:0] d_rdata;
    logic [15:0] p_rdata;
    logic [22:0] xaddr;
  } pdad_st_t;

  pdad_st_t st_ff;
  pdad_st_t nxt_st;
  logic [6:0] page;
  logic page_hit;

  pdad_page_reg u_page (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .data_req_in(data_req_in),
    .page_out(page),
    .hit_out(page_hit)
  );

  function automatic logic in_ram(input logic [15:0] a);
    in_ram = (a >= PDAD_RAM_LO) && (a <= PDAD_RAM_HI);
  endfunction

  function automatic pdad_route_t mk(input pdad_req_t r, input logic [6:0] pg, input logic en);
    mk.valid = r.valid && en;
    mk.write = r.write;
    mk.addr = {pg, r.addr};
    mk.wdata = r.wdata;
  endfunction

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic d_on;
  logic p_on;
  logic p_ext;

  always_comb begin
    d_on = in_ram(data_req_in.addr);
    // Overlay on: every page shows RAM low; off: no RAM in program space
    p_on = st_ff.ram_overlay_enable && in_ram(prog_req_in.addr);
    p_ext = !p_on;
    nxt_st = st_ff;
    // Overlay is a strap-like pin: two flops before use, only the second is read
    nxt_st.ram_overlay_enable_s1 = ram_overlay_enable_in;
    nxt_st.ram_overlay_enable = st_ff.ram_overlay_enable_s1;
    nxt_st.ready = ext_ready_in;
    nxt_st.ram_d = mk(data_req_in, 7'h00, d_on);
    nxt_st.ext_d = mk(data_req_in, 7'h00, !d_on && !page_hit);
    nxt_st.ram_p = mk(prog_req_in, page, p_on);
    nxt_st.ext_p = mk(prog_req_in, page, p_ext);
    nxt_st.xaddr = {page, prog_req_in.addr};
    if (page_hit) begin
      nxt_st.d_rdata = {9'h000, page};
    end else if (d_on) begin
      nxt_st.d_rdata = ram_data_rdata_in;
    end else begin
      nxt_st.d_rdata = ext_data_rdata_in;
    end
    nxt_st.p_rdata = p_on ? ram_prog_rdata_in : ext_prog_rdata_in;
  end

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign ram_data_out = st_ff.ram_d;
  assign ram_prog_out = st_ff.ram_p;
  assign ext_data_out = st_ff.ext_d;
  assign ext_prog_out = st_ff.ext_p;
  assign data_rdata_out = st_ff.d_rdata;
  assign prog_rdata_out = st_ff.p_rdata;
  assign prog_xaddr_out = st_ff.xaddr;
  // Only external accesses stall the core
  assign wait_out = (st_ff.ext_d.valid || st_ff.ext_p.valid) && !st_ff.ready;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);

  // A data-space write that lands in the page register
  sequence page_write_s;
    data_req_in.valid && data_req_in.write && (data_req_in.addr == PDAD_PAGE_REG_ADDR);
  endsequence

  // One quiet data cycle, so no second page write can slip in
  sequence data_idle_s;
    !data_req_in.valid;
  endsequence

  // A program fetch from the core
  sequence fetch_s;
    prog_req_in.valid;
  endsequence

  // An external data access while the far side is still busy
  sequence ext_busy_s;
    data_req_in.valid && !in_ram(data_req_in.addr)
      && (data_req_in.addr != PDAD_PAGE_REG_ADDR) && !ext_ready_in;
  endsequence

  data_ram_route_a: assert property (
    data_req_in.valid && in_ram(data_req_in.addr)
    |=> ram_data_out.valid && !ext_data_out.valid)
    else $error("in-range data access not sent to ram");

  ram_read_data_a: assert property (
    data_req_in.valid && !data_req_in.write && in_ram(data_req_in.addr)
    |=> data_rdata_out == $past(ram_data_rdata_in))
    else $error("on-chip read data not returned");

  data_zero_ext_a: assert property (
    data_req_in.valid
    |=> ram_data_out.addr[22:16] == 7'h00 && ext_data_out.addr[22:16] == 7'h00)
    else $error("data address left the data space");

  data_ext_route_a: assert property (
    data_req_in.valid && !in_ram(data_req_in.addr)
    && data_req_in.addr != PDAD_PAGE_REG_ADDR
    |=> ext_data_out.valid && !ram_data_out.valid)
    else $error("out-of-range data access not external");

  ext_stall_a: assert property (
    ext_busy_s |=> wait_out)
    else $error("busy external access did not stall");

  ram_no_wait_a: assert property (
    ram_data_out.valid && !ext_prog_out.valid |-> !wait_out)
    else $error("wait on on-chip access");

  prog_ram_route_a: assert property (
    prog_req_in.valid && st_ff.ram_overlay_enable && in_ram(prog_req_in.addr)
    |=> ram_prog_out.valid && !ext_prog_out.valid)
    else $error("overlay fetch not on-chip");

  prog_ext_route_a: assert property (
    prog_req_in.valid && !in_ram(prog_req_in.addr)
    |=> ext_prog_out.valid && !ram_prog_out.valid)
    else $error("out-of-range fetch not external");

  ext_fetch_data_a: assert property (
    prog_req_in.valid && !(st_ff.ram_overlay_enable && in_ram(prog_req_in.addr))
    |=> prog_rdata_out == $past(ext_prog_rdata_in))
    else $error("external fetch data not returned");

  xaddr_form_a: assert property (
    1'b1 |=> prog_xaddr_out == {$past(page), $past(prog_req_in.addr)})
    else $error("extended address malformed");

  page_select_a: assert property (
    page_write_s ##1 data_idle_s ##1 fetch_s
    |=> prog_xaddr_out[22:16] == $past(data_req_in.wdata[6:0], 3))
    else $error("fetch not on the page just written");

  page_hold_a: assert property (
    !(data_req_in.valid && data_req_in.write && data_req_in.addr == PDAD_PAGE_REG_ADDR)
    |=> $stable(page))
    else $error("page changed without a page write");

  ram_overlay_enable_sync_a: assert property (
    1'b1 |-> st_ff.ram_overlay_enable == $past(ram_overlay_enable_in, 2))
    else $error("overlay pin not seen after two flops");

  ram_overlay_enable_off_ext_a: assert property (
    prog_req_in.valid && !st_ff.ram_overlay_enable
    |=> !ram_prog_out.valid && ext_prog_out.valid)
    else $error("overlay off fetch reached ram");

  page_refuse_a: assert property (
    data_req_in.valid && data_req_in.addr == PDAD_PAGE_REG_ADDR
    |=> !ram_data_out.valid && !ext_data_out.valid)
    else $error("page register access routed out");

  page_read_a: assert property (
    data_req_in.valid && !data_req_in.write && data_req_in.addr == PDAD_PAGE_REG_ADDR
    |=> data_rdata_out == {9'h000, $past(page)})
    else $error("page register read wrong");

endmodule // pdad_decoder

// file: tb/pdad_mem_model.sv
// Behavioural on-chip RAM and external memory answering the decoder
`timescale 1ns/1ps
module pdad_mem_model
  import pdad_pkg::*;
(
  // Core requests seen this cycle
  input wire pdad_req_t data_req_in,
  input wire pdad_req_t prog_req_in,
  // Stall control from the bench
  input wire logic slow_in,
  // Answers
  output logic [15:0] ram_data_rdata_out,
  output logic [15:0] ram_prog_rdata_out,
  output logic [15:0] ext_data_rdata_out,
  output logic [15:0] ext_prog_rdata_out,
  output logic ext_ready_out
);
  // A distinct pattern per memory, so a wrong route shows in the data
  assign ram_data_rdata_out = data_req_in.addr ^ 16'hA5A5;
  assign ext_data_rdata_out = data_req_in.addr ^ 16'h3C3C;
  assign ram_prog_rdata_out = ~prog_req_in.addr;
  assign ext_prog_rdata_out = prog_req_in.addr ^ 16'hC3C3;
  // A slow device holds ready low and the core must stall
  assign ext_ready_out = ~slow_in;
endmodule // pdad_mem_model

// file: tb/pdad_decoder_tb.sv
// Self-checking bench for the address decoder
`timescale 1ns/1ps
module pdad_decoder_tb
  import pdad_pkg::*;
;
  logic sys_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic ram_overlay_enable = 1'b0;
  logic slow = 1'b0;
  pdad_req_t dreq = '0;
  pdad_req_t preq = '0;
  pdad_route_t rd, rp, ed, ep;
  logic [15:0] rdr, rpr, edr, epr, drd, prd;
  logic rdy, wt;
  logic [22:0] xa;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  always #5 sys_clk_in = ~sys_clk_in;
  pdad_decoder pdad_decoder_i (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
    .ram_overlay_enable_in(ram_overlay_enable), .data_req_in(dreq), .prog_req_in(preq),
    .ram_data_out(rd), .ram_prog_out(rp), .ram_data_rdata_in(rdr),
    .ram_prog_rdata_in(rpr), .ext_data_out(ed), .ext_prog_out(ep),
    .ext_data_rdata_in(edr), .ext_prog_rdata_in(epr), .ext_ready_in(rdy),
    .data_rdata_out(drd), .prog_rdata_out(prd), .wait_out(wt), .prog_xaddr_out(xa));
  pdad_mem_model pdad_mem_model_i (.data_req_in(dreq), .prog_req_in(preq),
    .slow_in(slow), .ram_data_rdata_out(rdr), .ram_prog_rdata_out(rpr),
    .ext_data_rdata_out(edr), .ext_prog_rdata_out(epr), .ext_ready_out(rdy));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One request held for one edge; outputs are sampled while they stand
  task automatic go(input logic p, input logic w, input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk_in) #1;
    if (p) begin
      preq = '{1'b1, w, a, d};
    end else begin
      dreq = '{1'b1, w, a, d};
    end
    @(posedge sys_clk_in) #1;
    dreq = '0;
    preq = '0;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_data;
    logic [15:0] a [6] = '{16'h0080, 16'h9FFF, 16'h0100, 16'h007F, 16'hA000, 16'hFFFF};
    go(0, 0, 16'h001E, 16'h0000);
    chk("page_reset", 24'h0, drd);
    for (int i = 0; i < 6; i++) begin
      go(0, 0, a[i], 16'h0000);
      chk("wait", 24'h0, wt);
      if (i < 3) begin
        chk("ram_data", {1'b1, 7'h0, a[i]}, {rd.valid, rd.addr});
        chk("ram_rd", a[i] ^ 16'hA5A5, drd);
      end else begin
        chk("ext_data", {1'b1, 7'h0, a[i]}, {ed.valid, ed.addr});
        chk("ext_rd", a[i] ^ 16'h3C3C, drd);
      end
    end
    go(0, 1, 16'h4000, 16'h1234);
    chk("ram_wr", {8'h3, 16'h1234}, {rd.valid, rd.write, rd.wdata});
    go(0, 1, 16'hC000, 16'hABCD);
    chk("ext_wr", {8'h3, 16'hABCD}, {ed.valid, ed.write, ed.wdata});
  endtask
  // Page write, then a fetch on it two edges later, then read back
  task automatic t_page;
    go(0, 1, 16'h001E, 16'h0005);
    chk("page_no_route", 24'h0, {rd.valid, ed.valid});
    go(1, 0, 16'h8000, 16'h0000);
    chk("ext_prog", {1'b1, 23'h058000}, {ep.valid, ep.addr});
    chk("xaddr", 24'h058000, xa);
    chk("ram_prog_off", 24'h0, rp.valid);
    chk("prog_rd", 16'h8000 ^ 16'hC3C3, prd);
    go(0, 0, 16'h001E, 16'h0000);
    chk("page_rd", 24'h5, drd);
    go(0, 1, 16'h001E, 16'hFFFF);
    go(0, 0, 16'h001E, 16'h0000);
    chk("page_top", 24'h7F, drd);
  endtask
  task automatic t_ram_overlay_enable;
    ram_overlay_enable = 1'b1;
    // Pin passes a synchroniser, so allow it to settle
    repeat (4) @(posedge sys_clk_in);
    go(1, 0, 16'h0100, 16'h0000);
    chk("ram_prog", {1'b1, 23'h7F0100}, {rp.valid, rp.addr});
    chk("ram_prog_rd", {8'h00, ~16'h0100}, prd);
    chk("prog_wait", 24'h0, wt);
    go(1, 0, 16'hA000, 16'h0000);
    chk("ext_prog_ovl", {1'b1, 23'h7FA000}, {ep.valid, ep.addr});
    ram_overlay_enable = 1'b0;
  endtask
  task automatic t_wait;
    slow = 1'b1;
    go(0, 0, 16'hC000, 16'h0000);
    chk("ext_wait", 24'h1, wt);
    go(0, 0, 16'h0200, 16'h0000);
    chk("ram_nowait", 24'h0, wt);
    slow = 1'b0;
  endtask
  // Mid-run reset with the page at its top value must bring page zero back
  task automatic t_reset;
    nrst_in = 1'b0;
    repeat (5) @(posedge sys_clk_in);
    #1 nrst_in = 1'b1;
    chk("rst_xaddr", 24'h0, xa);
    chk("rst_route", 24'h0, {rd.valid, rp.valid, ed.valid, ep.valid});
    go(0, 0, 16'h001E, 16'h0000);
    chk("rst_page", 24'h0, drd);
    chk("rst_xpage", 24'h0, xa);
  endtask
  // ----------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (5) @(posedge sys_clk_in);
    #1 nrst_in = 1'b1;
    t_data();
    t_page();
    t_ram_overlay_enable();
    t_wait();
    t_reset();
    tally_and_finish();
  end
endmodule // pdad_decoder_tb
